// ### bcp_pkg.sv
// Constants and types shared by both ends of the byte-wide configuration port.
// Assumes both ends run on clk_sys at 40 MHz.
package bcp_pkg;

  // ****************************************
  // Clock and link timing
  // ****************************************
  localparam int CLK_SYS_MHZ = 40;
  localparam int CLK_SYS_PERIOD_NS = 25;
  // Link clock ceilings with and without the busy handshake
  localparam int HS_LIMIT_MHZ = 66;
  localparam int NH_LIMIT_MHZ = 50;
  localparam int NH_PERIOD_PS = 1000000 / NH_LIMIT_MHZ;
  // Byte digest time: cycles that fit one no-handshake period (none at 40 MHz), never below one cycle
  localparam int PROC_CYC_RAW = NH_PERIOD_PS / (CLK_SYS_PERIOD_NS * 1000);
  localparam int PROC_CYC = (PROC_CYC_RAW < 1) ? 1 : PROC_CYC_RAW;
  localparam int ABORT_CYC_DEF = 16;
  // Half period of the link clock; both ends need six cycles for sync
  localparam int CONFIG_CLOCK_HALF_DEF = 8;
  localparam int CONFIG_CLOCK_HALF_MIN = 6;

  // ****************************************
  // Widths, codes and patterns
  // ****************************************
  localparam int DATA_W = 8;
  localparam int WORD_W = 32;
  localparam int MODE_W = 3;
  localparam int LEN_W = 8;
  localparam logic [MODE_W-1:0] MODE_MS_A = 3'h0;
  localparam logic [MODE_W-1:0] MODE_MS_B = 3'h4;
  localparam logic [WORD_W-1:0] SYNC_WORD_DEF = 32'hA5C35A3C;
  localparam logic [DATA_W-1:0] BUS_IDLE = 8'hFF;

  // ****************************************
  // State types
  // ****************************************
  typedef enum logic [1:0] {
    DS_IDLE = 2'h0,
    DS_WR = 2'h1,
    DS_ABORT = 2'h3,
    DS_RD = 2'h2
  } bcp_dev_st_t;

  typedef enum logic [1:0] {
    HS_IDLE = 2'h0,
    HS_WR = 2'h1,
    HS_ABORT = 2'h3,
    HS_RD = 2'h2
  } bcp_host_st_t;

endpackage : bcp_pkg

// ### bcp_link_if.sv
// Link between the configuration source and the configured device.
// The shared data bus is resolved here from both output enables.
`timescale 1ns/1ps
`default_nettype none
interface bcp_link_if;
  import bcp_pkg::*;

  logic config_clock;
  logic cs_n;
  logic write_n;
  logic busy;
  logic [DATA_W-1:0] host_d;
  logic host_oe;
  logic [DATA_W-1:0] dev_d;
  logic dev_oe;
  logic [DATA_W-1:0] data_bus;

  // Pulled-up bus; the source drives it first when both enables are up
  assign data_bus = host_oe ? host_d : (dev_oe ? dev_d : BUS_IDLE);

  modport host (
    output config_clock, cs_n, write_n, host_d, host_oe,
    input busy, data_bus
  );

  modport dev (
    input config_clock, cs_n, write_n, data_bus,
    output busy, dev_d, dev_oe
  );

endinterface : bcp_link_if
`default_nettype wire

// ### bcp_dev.sv
// Device end of the byte-wide configuration port.
// Assumes every incoming link pin is asynchronous to clk_sys and synchronises it.
//
// Functional notes
// [RULE_01] Accept one byte per transfer, paced by busy
// [RULE_02] Source supplies bytes, clock, select, write strobe
// [RULE_03] Source holds byte while busy is high
// [RULE_04] Selected with write high: drive readback data
// [RULE_05] After done, port released unless retained
// [RULE_06] Mode 000 or 100 selects master-serial
// [RULE_07] Shared lines; one device select at a time
// [RULE_08] Packet may span several select assertions
// [RULE_09] Write strobe constant while select stays low
// [RULE_10] Source releases bus during reads
// [RULE_11] Take byte at rise only if busy low
// [RULE_12] Source releases select and strobe when done
// [RULE_13] Clock limits 66 MHz handshake, 50 MHz without
// [RULE_14] Below no-handshake limit busy never rises
// [RULE_15] Direction change within select aborts packet
// [RULE_16] Busy held until abort completes
// [RULE_17] After abort, need new sync word
// [RULE_18] Write strobe high during write starts abort
// [RULE_19] Unsynced bytes only searched for sync word
`timescale 1ns/1ps
`default_nettype none
module bcp_dev
  import bcp_pkg::*;
#(
  parameter int PROC_CYCLES = PROC_CYC,
  parameter int ABORT_CYCLES = ABORT_CYC_DEF,
  parameter logic [WORD_W-1:0] SYNC_WORD = SYNC_WORD_DEF
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link
  bcp_link_if.dev link,
  // Mode straps
  input wire logic [MODE_W-1:0] config_mode_pins,
  // Configuration state from the core
  input wire logic cfg_done,
  input wire logic retain_port,
  // Readback source
  input wire logic [DATA_W-1:0] rb_data,
  output logic rb_take,
  // Received configuration words
  output logic [WORD_W-1:0] cfg_word,
  output logic cfg_word_valid,
  // Status
  output logic synced,
  output logic abort_seen,
  output logic master_serial,
  output logic port_released
);
  // ****************************************
  // Parameter checks
  // ****************************************
  localparam int PW = $clog2(PROC_CYCLES + 1);
  localparam int AW = $clog2(ABORT_CYCLES + 1);
  localparam int SW = 3 + DATA_W;
  if (PROC_CYCLES < 1 || ABORT_CYCLES < 1) begin : g_chk
    $error("bcp_dev: PROC_CYCLES and ABORT_CYCLES must be at least 1");
  end
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [SW-1:0] s1_r;
  logic [SW-1:0] s2_r;
  logic config_clock_d_r;
  logic [MODE_W-1:0] m1_r;
  logic [MODE_W-1:0] m2_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      config_clock_d_r <= 1'b0;
      m1_r <= '0;
      m2_r <= '0;
    end else begin
      s1_r <= {link.config_clock, link.cs_n, link.write_n, link.data_bus};
      s2_r <= s1_r;
      config_clock_d_r <= s2_r[SW-1];
      m1_r <= config_mode_pins;
      m2_r <= m1_r;
    end
  end

  wire config_clock_s = s2_r[SW-1];
  wire cs_act = !s2_r[SW-2];
  wire wr_act = !s2_r[SW-3];
  wire [DATA_W-1:0] din = s2_r[DATA_W-1:0];
  wire rise = config_clock_s && !config_clock_d_r;
  wire fall = !config_clock_s && config_clock_d_r;
  // ****************************************
  // Mode capture
  // ****************************************
  logic mode_cap_r;
  logic master_serial_r;
  // Straps are caught once, after the synchroniser has filled
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_cap_r <= 1'b0;
      master_serial_r <= 1'b0;
    end else if (!mode_cap_r && rise) begin
      mode_cap_r <= 1'b1;
      master_serial_r <= (m2_r == MODE_MS_A) || (m2_r == MODE_MS_B); // RULE_06
    end
  end
  // ****************************************
  // Port decode
  // ****************************************
  bcp_dev_st_t st_r;
  bcp_dev_st_t st_nxt;
  logic busy_r;
  logic [PW-1:0] proc_cnt_r;
  logic [AW-1:0] abort_cnt_r;
  wire port_on = mode_cap_r && !master_serial_r && (!cfg_done || retain_port); // RULE_05
  wire wr_port_on = port_on && !cfg_done;
  wire sel_rise = rise && cs_act && port_on;
  // A flip of direction in one select assertion aborts the packet
  wire dir_flip = sel_rise && ((st_r == DS_WR && !wr_act) || (st_r == DS_RD && wr_act)); // RULE_15 RULE_18
  wire wr_ok = (st_r == DS_IDLE) || (st_r == DS_WR);
  wire rd_ok = (st_r == DS_IDLE) || (st_r == DS_RD);
  wire wr_take = sel_rise && wr_act && wr_ok && !busy_r && wr_port_on; // RULE_01 RULE_11
  wire rd_step = sel_rise && !wr_act && rd_ok; // RULE_04
  wire abort_done = (st_r == DS_ABORT) && (abort_cnt_r == '0);
  wire proc_act = proc_cnt_r != '0;
  // ****************************************
  // Transfer state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      DS_IDLE: begin
        if (sel_rise) begin
          st_nxt = wr_act ? DS_WR : DS_RD;
        end
      end
      DS_WR, DS_RD: begin
        if (dir_flip) begin
          st_nxt = DS_ABORT;
        end else if (!cs_act) begin
          // Select released: the packet stays open for the next one
          st_nxt = DS_IDLE; // RULE_08
        end
      end
      DS_ABORT: begin
        if (abort_done) begin
          st_nxt = DS_IDLE;
        end
      end
      default: begin
        st_nxt = DS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= DS_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end
  // ****************************************
  // Byte digest and abort timers
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      proc_cnt_r <= '0;
      abort_cnt_r <= '0;
    end else begin
      if (wr_take) begin
        proc_cnt_r <= PW'(PROC_CYCLES);
      end else if (proc_act) begin
        proc_cnt_r <= proc_cnt_r - 1'b1;
      end
      if (dir_flip) begin
        abort_cnt_r <= AW'(ABORT_CYCLES - 1);
      end else if (st_r == DS_ABORT && !abort_done) begin
        abort_cnt_r <= abort_cnt_r - 1'b1;
      end
    end
  end

  // Busy changes only at falling link edges or while the port is off, so it is settled at each rise.
  // The digest fits one half period, so busy stays low without an abort.
  wire busy_nxt = port_on && (proc_act || st_r == DS_ABORT || dir_flip); // RULE_14 RULE_16
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
    end else if (fall || !port_on) begin
      busy_r <= busy_nxt; // RULE_01 RULE_03
    end
  end
  // ****************************************
  // Word alignment and sync search
  // ****************************************
  logic aligned_r;
  logic [WORD_W-1:0] sh_r;
  logic [1:0] bcnt_r;
  logic [WORD_W-1:0] word_r;
  logic word_vld_r;
  logic abort_r;
  wire [WORD_W-1:0] sh_nxt = {sh_r[WORD_W-DATA_W-1:0], din};
  wire sync_hit = !aligned_r && (sh_nxt == SYNC_WORD); // RULE_19
  wire word_end = aligned_r && (bcnt_r == 2'h3);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aligned_r <= 1'b0;
      sh_r <= '0;
      bcnt_r <= '0;
    end else if (dir_flip) begin
      // Alignment is lost; bytes are searched until a new sync word
      aligned_r <= 1'b0; // RULE_17
      sh_r <= '0;
      bcnt_r <= '0;
    end else if (wr_take) begin
      sh_r <= sh_nxt;
      bcnt_r <= aligned_r ? bcnt_r + 1'b1 : 2'h0;
      if (sync_hit) begin
        aligned_r <= 1'b1; // RULE_17
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      word_r <= '0;
      word_vld_r <= 1'b0;
      abort_r <= 1'b0;
    end else begin
      word_vld_r <= wr_take && word_end; // RULE_19
      abort_r <= dir_flip;
      if (wr_take && word_end) begin
        word_r <= sh_nxt;
      end
    end
  end
  // ****************************************
  // Readback drive
  // ****************************************
  logic [DATA_W-1:0] dout_r;
  logic oe_r;
  // Only drives while selected for a read, so the source has let go
  wire oe_nxt = port_on && cs_act && !wr_act && (st_nxt == DS_RD); // RULE_04 RULE_10

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dout_r <= BUS_IDLE;
      oe_r <= 1'b0;
    end else begin
      oe_r <= oe_nxt;
      if (rd_step) begin
        dout_r <= rb_data; // RULE_04
      end
    end
  end
  // ****************************************
  // Outputs
  // ****************************************
  assign link.busy = busy_r;
  assign link.dev_d = dout_r;
  assign link.dev_oe = oe_r;
  assign rb_take = rd_step;
  assign cfg_word = word_r;
  assign cfg_word_valid = word_vld_r;
  assign synced = aligned_r;
  assign abort_seen = abort_r;
  assign master_serial = master_serial_r;
  assign port_released = mode_cap_r && (master_serial_r || !port_on); // RULE_05
endmodule : bcp_dev
`default_nettype wire

// ### bcp_host.sv
// Source end of the byte-wide configuration port.
// Assumes one device on the link; makes the link clock from clk_sys.
`timescale 1ns/1ps
`default_nettype none
module bcp_host
  import bcp_pkg::*;
#(
  parameter int HALF = CONFIG_CLOCK_HALF_DEF,
  parameter bit IGNORE_BUSY = 1'b0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link
  bcp_link_if.host link,
  // Write stream
  input wire logic wr_valid,
  input wire logic [DATA_W-1:0] wr_data,
  output logic wr_ready,
  input wire logic abort_req,
  // Readback
  input wire logic rd_req,
  input wire logic [LEN_W-1:0] rd_len,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_valid,
  // Status
  output logic active
);

  // ****************************************
  // Parameter checks
  // ****************************************
  localparam int HW = $clog2(HALF);
  localparam int CONFIG_CLOCK_KHZ = (CLK_SYS_MHZ * 1000) / (2 * HALF);
  localparam int LIM_KHZ = (IGNORE_BUSY ? NH_LIMIT_MHZ : HS_LIMIT_MHZ) * 1000;

  if (HALF < CONFIG_CLOCK_HALF_MIN || CONFIG_CLOCK_KHZ > LIM_KHZ) begin : g_chk
    $error("bcp_host: HALF too small for synchronisers or clock limit"); // RULE_13
  end

  // ****************************************
  // Link clock divider
  // ****************************************
  logic [HW-1:0] hc_r;
  logic config_clock_r;
  wire wrap = hc_r == HW'(HALF - 1);
  wire rise_now = wrap && !config_clock_r;
  wire fall_now = wrap && config_clock_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hc_r <= '0;
      config_clock_r <= 1'b0;
    end else begin
      hc_r <= wrap ? '0 : hc_r + 1'b1;
      config_clock_r <= wrap ? !config_clock_r : config_clock_r;
    end
  end

  // ****************************************
  // Busy and bus synchronisers
  // ****************************************
  logic [DATA_W:0] h1_r;
  logic [DATA_W:0] h2_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      h1_r <= '0;
      h2_r <= '0;
    end else begin
      h1_r <= {link.busy, link.data_bus};
      h2_r <= h1_r;
    end
  end

  wire busy_s = h2_r[DATA_W];
  wire [DATA_W-1:0] bus_s = h2_r[DATA_W-1:0];

  // ****************************************
  // Transfer sequencer
  // ****************************************
  bcp_host_st_t st_r;
  logic cs_n_r;
  logic write_n_r;
  logic oe_r;
  logic [DATA_W-1:0] d_r;
  logic have_r;
  logic seen_r;
  logic [LEN_W-1:0] left_r;
  logic [DATA_W-1:0] rd_data_r;
  logic rd_vld_r;

  // Byte counts as taken at a rise that saw busy low, or at any rise with IGNORE_BUSY set
  wire taken = (st_r == HS_WR) && rise_now && have_r && (IGNORE_BUSY || !busy_s); // RULE_11
  wire rd_cap = (st_r == HS_RD) && fall_now && seen_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= HS_IDLE;
      cs_n_r <= 1'b1;
      write_n_r <= 1'b1;
      oe_r <= 1'b0;
      d_r <= BUS_IDLE;
      have_r <= 1'b0;
      seen_r <= 1'b0;
      left_r <= '0;
    end else begin
      if (taken) begin
        have_r <= 1'b0;
      end
      if (rise_now) begin
        seen_r <= 1'b1;
      end
      case (st_r)
        HS_IDLE: begin
          seen_r <= 1'b0;
          if (fall_now && wr_valid) begin
            cs_n_r <= 1'b0;
            write_n_r <= 1'b0;
            oe_r <= 1'b1;
            d_r <= wr_data;
            have_r <= 1'b1;
            st_r <= HS_WR;
          end else if (fall_now && rd_req && rd_len != '0) begin
            // Bus left to the device for the read
            cs_n_r <= 1'b0;
            write_n_r <= 1'b1; // RULE_10
            oe_r <= 1'b0;
            left_r <= rd_len;
            st_r <= HS_RD;
          end
        end
        HS_WR: begin
          if (fall_now && abort_req) begin
            write_n_r <= 1'b1; // RULE_18
            oe_r <= 1'b0;
            seen_r <= 1'b0;
            st_r <= HS_ABORT;
          end else if (fall_now && !have_r) begin
            if (wr_valid) begin
              d_r <= wr_data; // RULE_03
              have_r <= 1'b1;
            end else begin
              cs_n_r <= 1'b1; // RULE_12
              write_n_r <= 1'b1;
              oe_r <= 1'b0;
              st_r <= HS_IDLE;
            end
          end
        end
        HS_ABORT: begin
          if (fall_now && seen_r) begin
            cs_n_r <= 1'b1;
            have_r <= 1'b0;
            st_r <= HS_IDLE;
          end
        end
        HS_RD: begin
          if (rd_cap) begin
            seen_r <= 1'b0;
            left_r <= left_r - 1'b1;
            if (left_r == LEN_W'(1)) begin
              cs_n_r <= 1'b1; // RULE_12
              st_r <= HS_IDLE;
            end
          end
        end
        default: begin
          st_r <= HS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= '0;
      rd_vld_r <= 1'b0;
    end else begin
      rd_vld_r <= rd_cap;
      if (rd_cap) begin
        rd_data_r <= bus_s;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link.config_clock = config_clock_r; // RULE_02
  assign link.cs_n = cs_n_r; // RULE_07
  assign link.write_n = write_n_r; // RULE_09
  assign link.host_d = d_r;
  assign link.host_oe = oe_r;
  assign wr_ready = taken;
  assign rd_data = rd_data_r;
  assign rd_valid = rd_vld_r;
  assign active = st_r != HS_IDLE;

endmodule : bcp_host
`default_nettype wire

// ### bcp_chk.sv
// Concurrent checks on the link that joins source and device.
// Assumes the source divider HALF = 8 and the device default timing.
`timescale 1ns/1ps
`default_nettype none
module bcp_chk
  import bcp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link
  input wire logic config_clock,
  input wire logic cs_n,
  input wire logic write_n,
  input wire logic busy,
  input wire logic host_oe,
  input wire logic dev_oe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ****************************************
  // Assertions
  // ****************************************
  pins_at_fall_a: assert property (($changed(cs_n) || $changed(write_n)) |->
    $fell(config_clock)) else $error("select or strobe moved away from a link clock fall");
  busy_at_low_a: assert property ($changed(busy) |-> !config_clock)
    else $error("busy moved while the link clock was high");
  clk_high_a: assert property ($rose(config_clock) |-> config_clock[*8] ##1 !config_clock)
    else $error("link clock high phase is not eight cycles");
  clk_low_a: assert property ($fell(config_clock) |-> !config_clock[*8] ##1 config_clock)
    else $error("link clock low phase is not eight cycles");
  no_contend_a: assert property (!(host_oe && dev_oe))
    else $error("both ends drive the data bus");
  drive_write_a: assert property (host_oe |-> !cs_n && !write_n)
    else $error("source drives the bus outside a write");
  read_drive_a: assert property ($rose(dev_oe) |-> !cs_n && write_n)
    else $error("device drives the bus outside a read");
  read_release_a: assert property ($rose(cs_n) |-> ##[0:6] !dev_oe)
    else $error("device kept the bus after deselect");
  abort_busy_a: assert property ($rose(write_n) && !cs_n |-> ##[1:40] busy)
    else $error("no busy after a strobe change under select");
  busy_hold_a: assert property ($rose(busy) |-> busy[*6])
    else $error("busy dropped before the abort finished");

  // ****************************************
  // Coverage
  // ****************************************
  cover property ($rose(config_clock) && !cs_n && !write_n && !busy);
  cover property ($rose(dev_oe));
  cover property ($rose(busy));
endmodule : bcp_chk
`default_nettype wire

// ### tb_top.sv
// Self-checking bench: source and device face each other through one link.
// Assumes default divider and timing parameters of both ends.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import bcp_pkg::*;
;

  typedef struct {
    logic [MODE_W-1:0] mode;
    logic ms;
  } bcp_row_t;

  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [MODE_W-1:0] config_mode_pins = 3'h0;
  logic cfg_done = 1'b0;
  logic retain_port = 1'b0;
  logic [DATA_W-1:0] rb_data = 8'h40;
  logic wr_valid = 1'b0;
  logic [DATA_W-1:0] wr_data = 8'h00;
  logic abort_req = 1'b0;
  logic rd_req = 1'b0;
  logic [LEN_W-1:0] rd_len = 8'h01;
  wire rb_take;
  wire [WORD_W-1:0] cfg_word;
  wire cfg_word_valid;
  wire synced;
  wire abort_seen;
  wire master_serial;
  wire port_released;
  wire wr_ready;
  wire [DATA_W-1:0] rd_data;
  wire rd_valid;
  wire active;
  int fail_count = 0;
  int total_checks = 0;
  logic [WORD_W-1:0] wq[$];
  logic [DATA_W-1:0] rq[$];
  logic busy_seen = 1'b0;
  logic [DATA_W-1:0] rb_exp = 8'h40;
  bcp_row_t rows [8] = '{'{3'h0, 1'b1}, '{3'h1, 1'b0}, '{3'h2, 1'b0}, '{3'h3, 1'b0},
                         '{3'h4, 1'b1}, '{3'h5, 1'b0}, '{3'h6, 1'b0}, '{3'h7, 1'b0}};

  always #12.5 clk_sys = ~clk_sys;

  // ****************************************
  // Ends, link and checker
  // ****************************************
  bcp_link_if link();
  bcp_host u_bcp_host (.clk_sys(clk_sys), .rst_n(rst_n), .link(link), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_ready(wr_ready), .abort_req(abort_req), .rd_req(rd_req),
    .rd_len(rd_len), .rd_data(rd_data), .rd_valid(rd_valid), .active(active));
  bcp_dev u_bcp_dev (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
    .config_mode_pins(config_mode_pins), .cfg_done(cfg_done), .retain_port(retain_port),
    .rb_data(rb_data), .rb_take(rb_take), .cfg_word(cfg_word), .cfg_word_valid(cfg_word_valid),
    .synced(synced), .abort_seen(abort_seen), .master_serial(master_serial),
    .port_released(port_released));
  bcp_chk u_bcp_chk (.clk_sys(clk_sys), .rst_n(rst_n), .config_clock(link.config_clock),
    .cs_n(link.cs_n), .write_n(link.write_n), .busy(link.busy), .host_oe(link.host_oe),
    .dev_oe(link.dev_oe));

  // ****************************************
  // Monitors and readback source
  // ****************************************
  always @(negedge clk_sys) begin
    if (cfg_word_valid === 1'b1) wq.push_back(cfg_word);
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    if (link.busy === 1'b1) busy_seen = 1'b1;
  end

  always @(posedge clk_sys) begin
    if (rb_take === 1'b1) rb_data <= rb_data + 8'h01;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check_bit(input string name, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %0h seen %0h", name, exp, got);
    end
  endtask : check_bit

  task automatic check_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %0h seen %0h", name, exp, got);
    end
  endtask : check_byte

  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %0h seen %0h", name, exp, got);
    end
  endtask : check_word

  task automatic end_of_test;
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic do_reset;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (40) @(posedge clk_sys);
  endtask : do_reset

  // Keep set: wr_valid stays high and an abort is requested after the take
  task automatic send_byte(input logic [DATA_W-1:0] b, input bit keep);
    int n;
    n = 0;
    @(posedge clk_sys);
    wr_valid <= 1'b1;
    wr_data <= b;
    do begin
      @(negedge clk_sys);
      n++;
    end while (wr_ready !== 1'b1 && n < 200);
    check_bit("wr_ready", 1'b1, wr_ready);
    @(posedge clk_sys);
    wr_valid <= keep;
    abort_req <= keep;
  endtask : send_byte

  task automatic send_word(input logic [WORD_W-1:0] w);
    for (int i = 3; i >= 0; i--) begin
      send_byte(w[8*i +: 8], 1'b0);
    end
  endtask : send_word

  task automatic read_bytes(input logic [LEN_W-1:0] len);
    int n;
    n = 0;
    rq.delete();
    @(posedge clk_sys);
    rd_len <= len;
    rd_req <= 1'b1;
    do begin
      @(negedge clk_sys);
      n++;
    end while (active !== 1'b1 && n < 100);
    @(posedge clk_sys);
    rd_req <= 1'b0;
    repeat (40 * len + 40) @(posedge clk_sys);
    check_byte("read_count", len, 8'(rq.size()));
    for (int i = 0; i < len; i++) begin
      check_byte("read_data", rb_exp, rq[i]);
      rb_exp++;
    end
  endtask : read_bytes

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int n;
    for (int i = 0; i < 8; i++) begin
      config_mode_pins <= rows[i].mode;
      do_reset();
      check_bit("master_serial", rows[i].ms, master_serial);
    end
    config_mode_pins <= 3'h1;
    do_reset();
    busy_seen = 1'b0;
    wq.delete();
    send_byte(8'h00, 1'b0);
    send_byte(8'hFF, 1'b0);
    send_word(SYNC_WORD_DEF);
    repeat (20) @(posedge clk_sys);
    check_bit("synced", 1'b1, synced);
    check_byte("word_count", 8'h00, 8'(wq.size()));
    send_byte(8'h11, 1'b0);
    send_byte(8'h22, 1'b0);
    repeat (60) @(posedge clk_sys);
    send_byte(8'h33, 1'b0);
    send_byte(8'h44, 1'b0);
    repeat (20) @(posedge clk_sys);
    check_byte("word_count", 8'h01, 8'(wq.size()));
    check_word("cfg_word", 32'h11223344, wq[0]);
    check_bit("busy_seen", 1'b0, busy_seen);
    // Abort in mid-write
    send_byte(8'h55, 1'b1);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (abort_seen !== 1'b1 && n < 100);
    check_bit("abort_seen", 1'b1, abort_seen);
    @(posedge clk_sys);
    wr_valid <= 1'b0;
    abort_req <= 1'b0;
    repeat (80) @(posedge clk_sys);
    check_bit("synced", 1'b0, synced);
    check_bit("busy_seen", 1'b1, busy_seen);
    wq.delete();
    send_word(32'h11223344);
    repeat (20) @(posedge clk_sys);
    check_byte("word_count", 8'h00, 8'(wq.size()));
    send_word(SYNC_WORD_DEF);
    send_word(32'hC0FFEE01);
    repeat (20) @(posedge clk_sys);
    check_byte("word_count", 8'h01, 8'(wq.size()));
    check_word("cfg_word", 32'hC0FFEE01, wq[0]);
    read_bytes(8'h03);
    // Retained port after configuration done
    cfg_done <= 1'b1;
    retain_port <= 1'b1;
    repeat (5) @(posedge clk_sys);
    check_bit("port_released", 1'b0, port_released);
    read_bytes(8'h02);
    wq.delete();
    send_word(32'h12345678);
    repeat (20) @(posedge clk_sys);
    check_byte("word_count", 8'h00, 8'(wq.size()));
    retain_port <= 1'b0;
    repeat (5) @(posedge clk_sys);
    check_bit("port_released", 1'b1, port_released);
    // Reset in mid-run
    @(posedge clk_sys);
    rst_n <= 1'b0;
    @(negedge clk_sys);
    check_bit("cs_n", 1'b1, link.cs_n);
    check_bit("busy", 1'b0, link.busy);
    check_bit("synced", 1'b0, synced);
    check_bit("active", 1'b0, active);
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (40) @(posedge clk_sys);
    check_bit("master_serial", 1'b0, master_serial);
    check_bit("port_released", 1'b1, port_released);
    check_bit("synced", 1'b0, synced);
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
